// >>> hw/sar_adc_pkg.sv
// constants and types shared by the serial converter control block
package sar_adc_pkg;

  // ***************************************
  // timing
  // ***************************************
  localparam int CLK_MHZ = 40;
  localparam int T_CONV_NS = 1300;
  localparam int T_ACQ_NS = 240;
  // longest time: round down
  localparam int CONV_CYCLES = (T_CONV_NS * CLK_MHZ) / 1000;
  // least time: round up
  localparam int ACQ_CYCLES = (T_ACQ_NS * CLK_MHZ + 999) / 1000;

  // ***************************************
  // sizes and configuration word layout
  // ***************************************
  localparam int RES_BITS = 12;
  localparam int CFG_BITS = 6;
  localparam int CFG_SD = 5;
  localparam int CFG_OS = 4;
  localparam int CFG_S1 = 3;
  localparam int CFG_S0 = 2;
  localparam int CFG_UNI = 1;
  localparam int CFG_SLP = 0;
  localparam logic [5:0] CFG_RST = 6'h00;
  localparam logic [3:0] MUX_COMMON = 4'h8;
  localparam logic [7:0] BIT_TIME_RST = 8'(CONV_CYCLES / RES_BITS);

  // ***************************************
  // register map
  // ***************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam int CTRL_BIT_TIME_LSB = 0;
  localparam int STAT_CONVERTING = 0;
  localparam int STAT_ACQUIRING = 1;
  localparam int STAT_NAP = 2;
  localparam int STAT_SLEEP = 3;
  localparam int STAT_EARLY = 4;
  localparam int STAT_CFG_LSB = 8;

  typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_type;

endpackage

// >>> hw/sar_adc_ctrl.sv
// control logic of the eight-channel successive-approximation converter
`timescale 1ns/1ps
`default_nettype none

// How it works
// - each rising edge of the start pin while idle begins a conversion
// - start edges during a running conversion are ignored
// - six-bit configuration word shifted in between conversions steers next conversion
// - previous result shifts out on SDO while configuration shifts in
// - after the sixth configuration bit the selected input is acquired
// - bits are decided by successive approximation, most significant first
// - final result is loaded into twelve holding latches feeding the serial port
// - SDI is sampled on SCK rising edges
// - bit order: S/D, odd/sign, pair high, pair low, polarity, sleep
// - multiplexer is set from S/D, odd/sign and two pair-select bits
// - differential: pair chosen, odd/sign picks which channel is positive
// - single-ended: channel is twice pair plus odd bit, common is negative
// - all sixteen multiplexer codes give one positive and one negative input
// - positive and negative inputs are sampled at one instant
// - polarity bit selects unipolar or bipolar operation
// - sleep bit offers a sleep power-down between conversions
// - SDO is driven only while the start pin is low
// - bipolar gives two's complement, unipolar gives straight binary
// - SDO advances on each SCK falling edge, most significant bit first
// - start pin high at conversion end enters sleep or nap per sleep bit
module sar_adc_ctrl
  import sar_adc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CONVERSION_START_PIN,
  input wire logic SCK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire logic COMP_IN,
  output logic [11:0] DAC_CODE,
  output logic [3:0] MUX_POS,
  output logic [3:0] MUX_NEG,
  output logic SAMPLE,
  output logic BIPOLAR,
  output logic NAP,
  output logic SLEEP,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);

  // ***************************************
  // state
  // ***************************************
  typedef struct packed {
    conv_state_type state;
    logic conv_s1;
    logic conv_s2;
    logic conv_s3;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic comp_s1;
    logic comp_s2;
    logic [11:0] sar;
    logic [3:0] bit_idx;
    logic [7:0] bit_cnt;
    logic [11:0] result;
    logic [11:0] out_shift;
    logic [5:0] cfg_shift;
    logic [2:0] rx_cnt;
    logic [5:0] cfg;
    logic [5:0] conv_cfg;
    logic acquiring;
    logic [7:0] acq_cnt;
    logic early;
    logic nap;
    logic sleep;
    logic [7:0] bit_time;
    logic ack;
    logic [31:0] rdata;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  logic conv_rise;
  logic conv_low;
  logic sck_rise;
  logic sck_fall;
  logic bit_end;
  logic conv_end;
  logic [11:0] final_code;
  logic [11:0] coded;
  logic [5:0] cfg_in;
  logic take_sixth;
  logic wb_req;
  logic wr_ctrl;
  logic wr_status;
  logic early_set;

  assign conv_rise = st_r.conv_s2 & ~st_r.conv_s3;
  assign conv_low = ~st_r.conv_s2;
  assign sck_rise = st_r.sck_s2 & ~st_r.sck_s3;
  assign sck_fall = ~st_r.sck_s2 & st_r.sck_s3;
  assign bit_end = (st_r.state == ST_CONVERT) && (st_r.bit_cnt >= st_r.bit_time - 8'h01);
  assign conv_end = bit_end && (st_r.bit_idx == 4'h0);
  assign cfg_in = {st_r.cfg_shift[4:0], st_r.sdi_s2};
  // configuration is only taken while the port is enabled
  assign take_sixth = sck_rise && SDO_OE && (st_r.rx_cnt == 3'h5);
  assign wb_req = WB_CYC_I & WB_STB_I & ~st_r.ack;
  assign wr_ctrl = wb_req && WB_WE_I && (WB_ADR_I == REG_CTRL);
  assign wr_status = wb_req && WB_WE_I && (WB_ADR_I == REG_STATUS);
  // start seen before the minimum acquisition span has run out
  assign early_set = (st_r.state == ST_IDLE) && conv_rise && st_r.acquiring && (st_r.acq_cnt < 8'(ACQ_CYCLES));

  // current trial bit kept or dropped here so the latch sees all twelve decisions
  assign final_code = st_r.comp_s2 ? st_r.sar : (st_r.sar & ~(12'h001 << st_r.bit_idx));
  // offset binary from the array becomes two's complement by flipping the top bit
  assign coded = st_r.conv_cfg[CFG_UNI] ? final_code : {~final_code[11], final_code[10:0]};

  // ***************************************
  // next state
  // ***************************************
  always_comb
  begin
    st_nxt = st_r;
    // first stages feed only the second stages
    st_nxt.conv_s1 = CONVERSION_START_PIN;
    st_nxt.conv_s2 = st_r.conv_s1;
    st_nxt.conv_s3 = st_r.conv_s2;
    st_nxt.sck_s1 = SCK;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_s3 = st_r.sck_s2;
    st_nxt.sdi_s1 = SDI;
    st_nxt.sdi_s2 = st_r.sdi_s1;
    st_nxt.comp_s1 = COMP_IN;
    st_nxt.comp_s2 = st_r.comp_s1;

    if (st_r.acquiring && st_r.acq_cnt < 8'(ACQ_CYCLES))
    begin
      st_nxt.acq_cnt = st_r.acq_cnt + 8'h01;
    end

    unique case (st_r.state)
      ST_IDLE:
      begin
        if (conv_rise)
        begin
          // an early start still converts; the shortfall is only flagged
          if (early_set)
          begin
            st_nxt.early = 1'b1;
          end
          st_nxt.state = ST_CONVERT;
          st_nxt.acquiring = 1'b0;
          st_nxt.conv_cfg = st_r.cfg;
          st_nxt.sar = 12'h800;
          st_nxt.bit_idx = 4'hB;
          st_nxt.bit_cnt = 8'h00;
          st_nxt.nap = 1'b0;
          st_nxt.sleep = 1'b0;
        end
        else if (conv_low)
        begin
          // pin low wakes the converter up
          st_nxt.nap = 1'b0;
          st_nxt.sleep = 1'b0;
        end
      end
      ST_CONVERT:
      begin
        // start edges fall through unused here
        st_nxt.bit_cnt = st_r.bit_cnt + 8'h01;
        if (bit_end)
        begin
          st_nxt.bit_cnt = 8'h00;
          if (st_r.bit_idx == 4'h0)
          begin
            st_nxt.state = ST_IDLE;
            st_nxt.result = coded;
            st_nxt.out_shift = coded;
            st_nxt.rx_cnt = 3'h0;
            st_nxt.sleep = st_r.conv_s2 & st_r.conv_cfg[CFG_SLP];
            st_nxt.nap = st_r.conv_s2 & ~st_r.conv_cfg[CFG_SLP];
          end
          else
          begin
            // keep or drop the trial bit, then try the next lower one
            st_nxt.sar = final_code | (12'h001 << (st_r.bit_idx - 4'h1));
            st_nxt.bit_idx = st_r.bit_idx - 4'h1;
          end
        end
      end
    endcase

    if (sck_rise && SDO_OE && st_r.rx_cnt < 3'(CFG_BITS))
    begin
      st_nxt.cfg_shift = cfg_in;
      st_nxt.rx_cnt = st_r.rx_cnt + 3'h1;
    end
    if (take_sixth)
    begin
      st_nxt.cfg = cfg_in;
      st_nxt.acquiring = 1'b1;
      st_nxt.acq_cnt = 8'h00;
    end
    if (sck_fall && SDO_OE)
    begin
      st_nxt.out_shift = {st_r.out_shift[10:0], 1'b0};
    end

    // ***************************************
    // bus slave
    // ***************************************
    st_nxt.ack = wb_req;
    if (wr_ctrl && WB_SEL_I[0])
    begin
      st_nxt.bit_time = WB_DAT_I[CTRL_BIT_TIME_LSB +: 8];
    end
    // a new early start in the same cycle beats the clear
    if (wr_status && WB_SEL_I[0] && WB_DAT_I[STAT_EARLY] && !early_set)
    begin
      st_nxt.early = 1'b0;
    end
    if (wb_req && !WB_WE_I)
    begin
      st_nxt.rdata = 32'h00000000;
      unique case (WB_ADR_I)
        REG_CTRL:
        begin
          st_nxt.rdata[CTRL_BIT_TIME_LSB +: 8] = st_r.bit_time;
        end
        REG_STATUS:
        begin
          st_nxt.rdata[STAT_CONVERTING] = (st_r.state == ST_CONVERT);
          st_nxt.rdata[STAT_ACQUIRING] = st_r.acquiring;
          st_nxt.rdata[STAT_NAP] = st_r.nap;
          st_nxt.rdata[STAT_SLEEP] = st_r.sleep;
          st_nxt.rdata[STAT_EARLY] = st_r.early;
          st_nxt.rdata[STAT_CFG_LSB +: 6] = st_r.cfg;
        end
        REG_RESULT:
        begin
          st_nxt.rdata[11:0] = st_r.result;
        end
        default:
        begin
          st_nxt.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
      st_r.cfg <= CFG_RST;
      st_r.conv_cfg <= CFG_RST;
      st_r.bit_time <= BIT_TIME_RST;
    end
    else if (CE)
    begin
      st_r <= st_nxt;
    end
  end

  // ***************************************
  // outputs
  // ***************************************
  assign SDO_OE = (st_r.state == ST_IDLE) && conv_low;
  assign SDO = st_r.out_shift[11];
  assign DAC_CODE = st_r.sar;
  // pos channel is pair*2+odd in both modes; negative is partner or common
  assign MUX_POS = {1'b0, st_r.cfg[CFG_S1], st_r.cfg[CFG_S0], st_r.cfg[CFG_OS]};
  assign MUX_NEG = st_r.cfg[CFG_SD] ? MUX_COMMON
    : {1'b0, st_r.cfg[CFG_S1], st_r.cfg[CFG_S0], ~st_r.cfg[CFG_OS]};
  // one track signal drives both sides of the sampler
  assign SAMPLE = st_r.acquiring;
  assign BIPOLAR = ~st_r.conv_cfg[CFG_UNI];
  assign NAP = st_r.nap;
  assign SLEEP = st_r.sleep;
  assign WB_ACK_O = st_r.ack;
  assign WB_DAT_O = st_r.rdata;

  // ***************************************
  // checks
  // ***************************************
  AST_START: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    (st_r.state == ST_IDLE && conv_rise) |=> (st_r.state == ST_CONVERT && st_r.sar == 12'h800))
    else $error("start edge did not begin a conversion");
  AST_IGNORE: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    (st_r.state == ST_CONVERT && conv_rise && !conv_end) |=> (st_r.state == ST_CONVERT && $stable(st_r.conv_cfg)))
    else $error("start edge restarted a running conversion");
  AST_SAR_ORDER: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    (bit_end && !conv_end) |=> (st_r.bit_idx == $past(st_r.bit_idx) - 4'h1 && st_r.bit_cnt == 8'h00))
    else $error("approximation did not step down one bit");
  AST_LATCH: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    conv_end |=> (st_r.result == $past(coded) && st_r.out_shift == st_r.result && st_r.state == ST_IDLE))
    else $error("result not moved into holding latches");
  AST_CODING: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    (conv_end && !st_r.conv_cfg[CFG_UNI]) |=> (st_r.result[11] != $past(final_code[11])))
    else $error("bipolar result not in two's complement");
  AST_SDO_EN: assert property (@(posedge SYS_CLK) disable iff (RST)
    SDO_OE |-> (!st_r.conv_s2 && st_r.state == ST_IDLE))
    else $error("SDO driven while start pin high");
  AST_SHIFT: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    (sck_fall && SDO_OE) |=> (st_r.out_shift == {$past(st_r.out_shift[10:0]), 1'b0}))
    else $error("SDO did not advance on SCK falling edge");
  AST_CFG: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    take_sixth |=> (st_r.cfg == $past(cfg_in) && SAMPLE && st_r.rx_cnt == 3'h6))
    else $error("configuration word not applied after sixth bit");
  AST_MUX: assert property (@(posedge SYS_CLK) disable iff (RST)
    (MUX_NEG == MUX_COMMON) == st_r.cfg[CFG_SD] && MUX_POS != MUX_NEG)
    else $error("multiplexer assignment inconsistent with configuration");
  AST_POWER: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    (conv_end && st_r.conv_s2) |=> (SLEEP == $past(st_r.conv_cfg[CFG_SLP]) && NAP == !SLEEP))
    else $error("wrong power-down mode after conversion");
  AST_EARLY: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    early_set |=> st_r.early)
    else $error("early start not flagged");
  AST_HOLD_SAMPLE: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    (st_r.state == ST_CONVERT) |-> !SAMPLE)
    else $error("input tracked during conversion");
  AST_WAKE: assert property (@(posedge SYS_CLK) disable iff (RST || !CE)
    (st_r.state == ST_IDLE && conv_low) |=> (!NAP && !SLEEP))
    else $error("start pin low did not wake the converter");
  AST_FREEZE: assert property (@(posedge SYS_CLK) disable iff (RST)
    !CE |=> $stable(st_r))
    else $error("state moved while clock enable low");

endmodule // sar_adc_ctrl

`default_nettype wire

// >>> tb/spi_host.sv
// host model of the serial link: start pin, serial clock and config data
`timescale 1ns/1ps
`default_nettype none
module spi_host
(
  output logic conv_start,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  initial
  begin
    conv_start = 1'b0;
    sck = 1'b0;
    sdi = 1'b1;
  end
  // ******************
  // link tasks
  // ******************
  // 7 ns skew keeps link edges off the system clock edges
  task automatic pulse(input int hold_ns);
    #7;
    conv_start = 1'b1;
    #(hold_ns);
    conv_start = 1'b0;
  endtask
  // sdo taken just before each rise, 100 ns after the fall
  task automatic frame(input logic [5:0] cfg, input int nbits, output logic [11:0] data);
    data = 12'h000;
    #7;
    for (int k = 0; k < nbits; k++)
    begin
      sdi = (k < 6) ? cfg[5 - k] : ~sdi;
      #100;
      if (k < 12) data[11 - k] = sdo;
      sck = 1'b1;
      #100;
      sck = 1'b0;
    end
    #100;
    // idle data toggles so a stale bit cannot pass
    sdi = ~sdi;
  endtask
endmodule // spi_host
`default_nettype wire

// >>> tb/tb_sar_adc_serial_control.sv
// self-checking bench for the serial converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("Error at %0t got %h exp %h", $time, (a), (b)); end end
module tb_sar_adc_serial_control
  import sar_adc_pkg::*;
;
  logic sys_clk, rst, ce, conv, sck, sdi, sdo, sdo_oe, comp_in, sample, bipolar, nap, sleep;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [11:0] dac_code, target, exp_code, rd12;
  logic [3:0] mux_pos, mux_neg, wb_sel;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int failures = 0;
  int checks = 0;
  int n;
  // cfg, analog level, expected positive and negative input
  logic [27:0] rows [16] = '{28'h0000001, 28'h06FFF23, 28'h0880045, 28'h0E7FF67, 28'h1012310, 28'h16ABC32,
    28'h1855554, 28'h1EAAA76, 28'h2000108, 28'h26FFE28, 28'h283C348, 28'h2EC3C68, 28'h300F018, 28'h36F0F38,
    28'h387FE58, 28'h3E80178};
  // comparator: sampled input against the trial word
  assign comp_in = (target >= dac_code);
  sar_adc_ctrl u_dut (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .CONVERSION_START_PIN(conv), .SCK(sck),
    .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .COMP_IN(comp_in), .DAC_CODE(dac_code), .MUX_POS(mux_pos),
    .MUX_NEG(mux_neg), .SAMPLE(sample), .BIPOLAR(bipolar), .NAP(nap), .SLEEP(sleep), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_i),
    .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack));
  spi_host u_host (.conv_start(conv), .sck(sck), .sdi(sdi), .sdo(sdo));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ******************
  // tasks
  // ******************
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // request held until ack is sampled high; only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge sys_clk);
    end
    while (wb_ack !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wait_oe();
    int k;
    k = 0;
    while (sdo_oe !== 1'b1 && k < 400)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 400)
    begin
      failures++;
      summarize();
    end
  endtask
  // optional second start edge gap cycles after the first start pulse ends
  task automatic conv_time(input int gap, input int bt);
    time t0;
    @(posedge sys_clk);
    t0 = $time;
    u_host.pulse(100);
    `CHK({sample, dac_code}, 13'h0800)
    if (gap > 0)
    begin
      repeat (gap) @(posedge sys_clk);
      u_host.pulse(100);
    end
    wait_oe();
    n = int'(($time - t0) / 25);
    `CHK(n >= 12 * bt && n <= 12 * bt + 8, 1'b1)
  endtask
  // ******************
  // sequence
  // ******************
  initial
  begin
    {rst, ce, wb_cyc, wb_stb, wb_we} = 5'h18;
    {wb_sel, wb_adr, wb_dat_i, target} = {4'hF, 8'h00, 32'h0, 12'h000};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK({dac_code, mux_pos, mux_neg, sample, nap, sleep, bipolar}, 24'h000011)
    wb(1'b0, REG_CTRL, 32'h0, rd);
    `CHK(rd, {24'h0, BIT_TIME_RST})
    wb(1'b1, 8'hFC, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'hFC, 32'h0, rd);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 16; i++)
    begin
      wait_oe();
      u_host.frame(rows[i][25:20], 12, rd12);
      if (i > 0) `CHK(rd12, exp_code)
      `CHK({mux_pos, mux_neg}, rows[i][7:0])
      `CHK(sample, 1'b1)
      target = rows[i][19:8];
      exp_code = rows[i][21] ? target : target ^ 12'h800;
      u_host.pulse(100);
      wait_oe();
      `CHK(bipolar, ~rows[i][21])
      wb(1'b0, REG_RESULT, 32'h0, rd);
      `CHK(rd, {20'h0, exp_code})
    end
    wb(1'b0, REG_STATUS, 32'h0, rd);
    `CHK(rd[STAT_CFG_LSB +: 6], 6'h3E)
    // start right after the sixth bit: still converts, but flagged
    target = 12'h3C3;
    fork
      u_host.frame(6'h3E, 6, rd12);
      begin
        #1150;
        u_host.pulse(100);
      end
    join
    wait_oe();
    wb(1'b0, REG_STATUS, 32'h0, rd);
    `CHK(rd[STAT_EARLY], 1'b1)
    wb(1'b1, REG_STATUS, 32'h1 << STAT_EARLY, rd);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    `CHK(rd[STAT_EARLY], 1'b0)
    u_host.frame(6'h3E, 12, rd12);
    `CHK(rd12, 12'h3C3)
    target = 12'h5A5;
    conv_time(10, BIT_TIME_RST);
    exp_code = 12'h5A5;
    for (int s = 1; s >= 0; s--)
    begin
      u_host.frame({5'h00, s[0]}, 12, rd12);
      `CHK(rd12, exp_code)
      exp_code = 12'hDA5;
      fork
        u_host.pulse(3000);
        begin
          repeat (80) @(posedge sys_clk);
          `CHK({sleep, nap, sdo_oe}, {s[0], ~s[0], 1'b0})
        end
      join
      repeat (5) @(posedge sys_clk);
      `CHK({sleep, nap}, 2'b00)
    end
    wb(1'b1, REG_CTRL, 32'h6, rd);
    wb(1'b0, REG_CTRL, 32'h0, rd);
    `CHK(rd, 32'h6)
    wait_oe();
    u_host.frame(6'h02, 12, rd12);
    `CHK(rd12, exp_code)
    conv_time(0, 6);
    wb(1'b0, REG_RESULT, 32'h0, rd);
    `CHK(rd, 32'h5A5)
    // start pulse while frozen must leave no trace
    target = 12'h0F0;
    @(posedge sys_clk);
    ce <= 1'b0;
    u_host.pulse(100);
    @(posedge sys_clk);
    ce <= 1'b1;
    repeat (60) @(posedge sys_clk);
    `CHK({sdo_oe, dac_code}, 13'h15A5)
    // reset in mid-run: defaults back, bit time included
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK({dac_code, mux_pos, mux_neg, sample, nap, sleep, bipolar}, 24'h000011)
    wb(1'b0, REG_CTRL, 32'h0, rd);
    `CHK(rd, {24'h0, BIT_TIME_RST})
    wb(1'b0, REG_RESULT, 32'h0, rd);
    `CHK(rd, 32'h0)
    summarize();
  end
  initial
  begin
    #400000;
    failures++;
    summarize();
  end
endmodule // tb_sar_adc_serial_control
`default_nettype wire
